// >>> verilog/spcc_pkg.sv
// constants for the switch port control and buffer-two read block
//------------------------------------------------------------------
// Operation
// [RL1] address 7 read pops next buffer-two word
// [RL2] port n at serial n, cpu 2n
// [RL3] bit 0 clear enables flow control
// [RL4] bit 1 selects half duplex, default full
// [RL5] bit 2 selects 10 Mbps, default 100
// [RL6] bits 4:3 at 00 enable auto-negotiation
// [RL7] bit 5 stops pause transmit, keeps receive
// [RL8] spanning state drops, learns or forwards
// [RL9] cpu port non-mii: bits 5:0 reserved
// [RL10] host keeps cpu duplex bit cleared
// [RL11] cpu bit 3 brings mii port up
// [RL12] host writes cpu bit 4 as one
// [RL13] command bit 2 releases buffer two
// [RL14] interrupt bit 2 flags buffer two data
// [RL15] reserved bits read zero, writes ignored
//------------------------------------------------------------------
package spcc_pkg;
    // direct host addresses
    localparam logic [2:0] SPCC_A_IDX_LO = 3'h0;
    localparam logic [2:0] SPCC_A_IDX_HI = 3'h1;
    localparam logic [2:0] SPCC_A_DATA = 3'h2;
    localparam logic [2:0] SPCC_A_CMD = 3'h4;
    localparam logic [2:0] SPCC_A_IRQ = 3'h5;
    localparam logic [2:0] SPCC_A_BUF2 = 3'h7;
    // port control register offset and layout
    localparam logic [15:0] SPCC_PORT_CTRL_ONE_OFS = 16'h0000;
    localparam logic [7:0] SPCC_PORT_RST = 8'hc0;
    localparam int SPCC_B_FC = 0;
    localparam int SPCC_B_DUP = 1;
    localparam int SPCC_B_SPD = 2;
    localparam int SPCC_B_UP = 3;
    localparam int SPCC_B_AN_LO = 3;
    localparam int SPCC_B_AN_HI = 4;
    localparam int SPCC_B_ASYM = 5;
    localparam int SPCC_B_SS_LO = 6;
    localparam int SPCC_B_SS_HI = 7;
    localparam int SPCC_B_REL = 2;
    localparam int SPCC_B_IRQ2 = 2;
    localparam logic [7:0] SPCC_CPU_RSVD_MASK = 8'hc0;
    localparam logic [7:0] SPCC_ALL_MASK = 8'hff;
    localparam logic [1:0] SPCC_AN_ON = 2'b00;
    localparam logic [1:0] SPCC_SS_LEARN = 2'b10;
    localparam logic [1:0] SPCC_SS_FWD = 2'b11;
    // host access mode strap codes
    localparam logic [1:0] SPCC_MODE_PAR8 = 2'h0;
    localparam logic [1:0] SPCC_MODE_PAR16 = 2'h1;
    localparam logic [1:0] SPCC_MODE_SER = 2'h2;
    localparam logic [1:0] SPCC_MODE_SER_MII = 2'h3;
endpackage

// >>> verilog/spcc_top.sv
// port control registers and buffer-two host read path
`timescale 1ns/1ps
module spcc_top
    import spcc_pkg::*;
#(
    parameter int NUM_PORTS = 10,
    parameter int CPU_PORT = 8,
    parameter int BUF2_DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] host_mode,
    input wire logic [2:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    input wire logic [7:0] i2c_addr,
    input wire logic i2c_wr,
    input wire logic i2c_rd,
    input wire logic [7:0] i2c_wdata,
    output logic [7:0] i2c_rdata,
    output logic i2c_rvalid,
    input wire logic buf2_in_valid,
    input wire logic [15:0] buf2_in_data,
    input wire logic buf2_in_last,
    output logic buf2_in_ready,
    output logic [NUM_PORTS-1:0] fc_enable,
    output logic [NUM_PORTS-1:0] half_duplex,
    output logic [NUM_PORTS-1:0] speed_10,
    output logic [NUM_PORTS-1:0] autoneg_en,
    output logic [NUM_PORTS-1:0] pause_tx_en,
    output logic [NUM_PORTS-1:0] pause_rx_en,
    output logic [NUM_PORTS-1:0] stp_forward,
    output logic [NUM_PORTS-1:0] stp_learn,
    output logic mii_port_up
);
    //------------------------------------------------------------------
    // sizes and elaboration checks
    //------------------------------------------------------------------
    localparam int PW = $clog2(BUF2_DEPTH) + 1; // pointer with wrap bit
    localparam int AW = $clog2(BUF2_DEPTH); // memory index width

    // refuse sizes the decoders and pointers cannot serve, at elaboration
    if (NUM_PORTS < 1 || NUM_PORTS > 128 || CPU_PORT < 0 || CPU_PORT >= NUM_PORTS) begin : g_bad_ports
        $error("spcc_top: port count or cpu port out of range");
    end
    if (BUF2_DEPTH < 2 || (BUF2_DEPTH & (BUF2_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("spcc_top: buffer depth must be a power of two");
    end

    // whole block state, registered in one place
    typedef struct packed {
        logic [1:0] mode_meta; // first strap stage, read by mode_sync only
        logic [1:0] mode_sync; // settled host mode
        logic [NUM_PORTS-1:0][7:0] port; // first control register per port
        logic [15:0] index; // indirect address
        logic [BUF2_DEPTH-1:0][15:0] mem; // buffer-two words
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic done; // whole frame held, host may read
        logic [15:0] rdata;
        logic rvalid;
        logic [7:0] i2c_rdata;
        logic i2c_rvalid;
        logic [NUM_PORTS-1:0] fc;
        logic [NUM_PORTS-1:0] half;
        logic [NUM_PORTS-1:0] spd10;
        logic [NUM_PORTS-1:0] an;
        logic [NUM_PORTS-1:0] ptx;
        logic [NUM_PORTS-1:0] prx;
        logic [NUM_PORTS-1:0] fwd;
        logic [NUM_PORTS-1:0] lrn;
        logic mii_up;
    } spcc_state_t;

    spcc_state_t s_reg;
    spcc_state_t s_next;

    //------------------------------------------------------------------
    // helpers for the host and serial access paths
    //------------------------------------------------------------------
    // writable bits of a port register; cpu port outside mii keeps only ss
    function automatic logic [7:0] wmask(input int p, input logic mii);
        if (p == CPU_PORT && !mii) begin
            wmask = SPCC_CPU_RSVD_MASK; // RL9 RL15
        end else begin
            wmask = SPCC_ALL_MASK;
        end
    endfunction

    // cpu indirect address to port, -1 when no port register there
    function automatic int cpu_port_of(input logic [15:0] a);
        logic [15:0] rel;
        rel = a - SPCC_PORT_CTRL_ONE_OFS;
        if (!rel[0] && rel[15:1] < 15'(NUM_PORTS)) begin
            cpu_port_of = int'(rel[15:1]); // RL2
        end else begin
            cpu_port_of = -1;
        end
    endfunction

    // serial-bus address to port
    function automatic int ser_port_of(input logic [7:0] a);
        if (a < 8'(NUM_PORTS)) begin
            ser_port_of = int'(a); // RL2
        end else begin
            ser_port_of = -1;
        end
    endfunction

    //------------------------------------------------------------------
    // next-state logic
    //------------------------------------------------------------------
    logic mii; // cpu port in serial plus mii mode
    logic empty;
    logic full;
    logic push;
    logic pop;
    int hp; // port addressed by host indirect access
    int sp; // port addressed by serial bus

    assign mii = (s_reg.mode_sync == SPCC_MODE_SER_MII);
    assign empty = (s_reg.wptr == s_reg.rptr);
    assign full = (s_reg.wptr[AW-1:0] == s_reg.rptr[AW-1:0]) && !empty;
    // filling stalls while a whole frame waits for the host
    assign buf2_in_ready = !full && !s_reg.done;
    assign push = buf2_in_valid && buf2_in_ready;
    assign pop = host_rd && host_addr == SPCC_A_BUF2 && !empty;
    assign hp = cpu_port_of(s_reg.index);
    assign sp = ser_port_of(i2c_addr);

    always_comb begin
        logic [7:0] r;
        r = 8'h00;
        s_next = s_reg;
        s_next.mode_meta = host_mode;
        s_next.mode_sync = s_reg.mode_meta;
        s_next.rvalid = 1'b0;
        s_next.i2c_rvalid = 1'b0;
        // serial-bus path; host path below wins on a same-port clash
        if (i2c_wr && sp >= 0) begin
            s_next.port[sp] = i2c_wdata & wmask(sp, mii); // RL2
        end
        if (i2c_rd) begin
            s_next.i2c_rvalid = 1'b1;
            s_next.i2c_rdata = (sp >= 0) ? s_reg.port[sp] : 8'h00;
        end
        // host direct register writes
        if (host_wr) begin
            if (host_addr == SPCC_A_IDX_LO) begin
                if (s_reg.mode_sync == SPCC_MODE_PAR8) begin
                    s_next.index[7:0] = host_wdata[7:0];
                end else begin
                    s_next.index = host_wdata;
                end
            end else if (host_addr == SPCC_A_IDX_HI) begin
                // upper index byte only matters in 8-bit mode
                if (s_reg.mode_sync == SPCC_MODE_PAR8) begin
                    s_next.index[15:8] = host_wdata[7:0];
                end
            end else if (host_addr == SPCC_A_DATA) begin
                if (hp >= 0) begin
                    s_next.port[hp] = host_wdata[7:0] & wmask(hp, mii); // RL2 RL15
                end
            end else if (host_addr == SPCC_A_CMD) begin
                // release is one-shot: nothing is stored, so it self-clears
                if (host_wdata[SPCC_B_REL] && s_reg.done) begin
                    s_next.done = 1'b0; // RL13
                    s_next.rptr = '0;
                    s_next.wptr = '0;
                end
            end
        end
        // host direct register reads, answered one cycle later
        if (host_rd) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = 16'h0000;
            if (host_addr == SPCC_A_DATA) begin
                s_next.rdata = {8'h00, (hp >= 0) ? s_reg.port[hp] : 8'h00};
            end else if (host_addr == SPCC_A_CMD) begin
                s_next.rdata[SPCC_B_REL] = s_reg.done; // RL13
            end else if (host_addr == SPCC_A_IRQ) begin
                s_next.rdata[SPCC_B_IRQ2] = s_reg.done; // RL14
            end else if (host_addr == SPCC_A_BUF2) begin
                // each read hands out the next word; empty reads give zero
                if (!empty) begin
                    s_next.rdata = s_reg.mem[s_reg.rptr[AW-1:0]]; // RL1
                end
            end
        end
        if (pop) begin
            s_next.rptr = s_reg.rptr + PW'(1); // RL1
        end
        // switch side fills buffer two
        if (push) begin
            s_next.mem[s_reg.wptr[AW-1:0]] = buf2_in_data;
            s_next.wptr = s_reg.wptr + PW'(1);
            if (buf2_in_last) begin
                s_next.done = 1'b1; // RL14
            end
        end
        // leaving mii mode drops the cpu bits that become reserved
        s_next.port[CPU_PORT] = s_next.port[CPU_PORT] & wmask(CPU_PORT, mii); // RL9
        // decoded port controls
        for (int i = 0; i < NUM_PORTS; i++) begin
            r = s_next.port[i];
            s_next.fc[i] = !r[SPCC_B_FC]; // RL3
            s_next.half[i] = r[SPCC_B_DUP]; // RL4
            s_next.spd10[i] = r[SPCC_B_SPD]; // RL5
            s_next.an[i] = (r[SPCC_B_AN_HI:SPCC_B_AN_LO] == SPCC_AN_ON); // RL6
            s_next.prx[i] = s_next.fc[i]; // RL7
            s_next.ptx[i] = s_next.fc[i] && !r[SPCC_B_ASYM]; // RL7
            s_next.fwd[i] = (r[SPCC_B_SS_HI:SPCC_B_SS_LO] == SPCC_SS_FWD); // RL8
            s_next.lrn[i] = r[SPCC_B_SS_HI]; // RL8
        end
        // cpu port: link settings count only while the mii port is up
        r = s_next.port[CPU_PORT];
        s_next.mii_up = mii && r[SPCC_B_UP]; // RL11
        s_next.an[CPU_PORT] = 1'b0;
        if (!s_next.mii_up) begin
            s_next.fc[CPU_PORT] = 1'b0; // RL9 RL11
            s_next.half[CPU_PORT] = 1'b0;
            s_next.spd10[CPU_PORT] = 1'b0;
            s_next.ptx[CPU_PORT] = 1'b0;
            s_next.prx[CPU_PORT] = 1'b0;
        end
    end

    //------------------------------------------------------------------
    // state register, synchronous reset
    //------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            for (int i = 0; i < NUM_PORTS; i++) begin
                s_reg.port[i] <= SPCC_PORT_RST; // RL3 RL4 RL5 RL6 RL7 RL8
                s_reg.fc[i] <= 1'b1;
                s_reg.prx[i] <= 1'b1;
                s_reg.ptx[i] <= 1'b1;
                s_reg.an[i] <= 1'b1;
                s_reg.fwd[i] <= 1'b1;
                s_reg.lrn[i] <= 1'b1;
            end
            // cpu port starts down until mii mode and a set bit 3 bring it up
            s_reg.fc[CPU_PORT] <= 1'b0;
            s_reg.prx[CPU_PORT] <= 1'b0;
            s_reg.ptx[CPU_PORT] <= 1'b0;
            s_reg.an[CPU_PORT] <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign host_rdata = s_reg.rdata;
    assign host_rvalid = s_reg.rvalid;
    assign i2c_rdata = s_reg.i2c_rdata;
    assign i2c_rvalid = s_reg.i2c_rvalid;
    assign fc_enable = s_reg.fc;
    assign half_duplex = s_reg.half;
    assign speed_10 = s_reg.spd10;
    assign autoneg_en = s_reg.an;
    assign pause_tx_en = s_reg.ptx;
    assign pause_rx_en = s_reg.prx;
    assign stp_forward = s_reg.fwd;
    assign stp_learn = s_reg.lrn;
    assign mii_port_up = s_reg.mii_up;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    localparam int MP = 1; // mac port watched by checks, the one the scenarios exercise

    sequence s_host_wr_mp;
        host_wr && host_addr == SPCC_A_DATA && s_reg.index == 16'(2 * MP);
    endsequence

    sequence s_i2c_wr_mp;
        i2c_wr && i2c_addr == 8'(MP) && !(host_wr && host_addr == SPCC_A_DATA);
    endsequence

    property p_buf2_pop;
        pop |=> host_rvalid && s_reg.rptr == $past(s_reg.rptr) + PW'(1)
            && host_rdata == $past(s_reg.mem[s_reg.rptr[AW-1:0]]);
    endproperty
    a_buf2_pop: assert property (p_buf2_pop) else $error("buffer two read did not pop"); // RL1

    property p_i2c_write;
        s_i2c_wr_mp |=> s_reg.port[MP] == $past(i2c_wdata);
    endproperty
    a_i2c_write: assert property (p_i2c_write) else $error("serial write not stored"); // RL2

    property p_fc_disable;
        s_host_wr_mp ##0 host_wdata[SPCC_B_FC] |-> ##1 1'b1 ##1 !fc_enable[MP];
    endproperty
    a_fc_disable: assert property (p_fc_disable) else $error("flow control not off"); // RL3

    property p_speed_duplex;
        s_reg.port[MP][SPCC_B_SPD] && s_reg.port[MP][SPCC_B_DUP]
            |-> speed_10[MP] && half_duplex[MP];
    endproperty
    a_speed_duplex: assert property (p_speed_duplex) else $error("speed or duplex wrong"); // RL4 RL5

    property p_autoneg;
        s_reg.port[MP][SPCC_B_AN_HI:SPCC_B_AN_LO] != SPCC_AN_ON |-> !autoneg_en[MP];
    endproperty
    a_autoneg: assert property (p_autoneg) else $error("autoneg on with nonzero field"); // RL6

    property p_asym;
        s_reg.port[MP][SPCC_B_ASYM] && !s_reg.port[MP][SPCC_B_FC]
            |-> !pause_tx_en[MP] && pause_rx_en[MP];
    endproperty
    a_asym: assert property (p_asym) else $error("asymmetric pause wrong"); // RL7

    property p_stp_learning;
        s_reg.port[MP][SPCC_B_SS_HI:SPCC_B_SS_LO] == SPCC_SS_LEARN
            |-> stp_learn[MP] && !stp_forward[MP];
    endproperty
    a_stp_learning: assert property (p_stp_learning) else $error("learning state wrong"); // RL8

    property p_cpu_rsvd;
        !mii && $stable(s_reg.mode_sync) |=> (s_reg.port[CPU_PORT] & ~SPCC_CPU_RSVD_MASK) == 8'h00
            && !fc_enable[CPU_PORT];
    endproperty
    a_cpu_rsvd: assert property (p_cpu_rsvd) else $error("cpu reserved bits set"); // RL9 RL15

    property p_mii_down;
        mii_port_up |-> s_reg.port[CPU_PORT][SPCC_B_UP];
    endproperty
    a_mii_down: assert property (p_mii_down) else $error("mii up while bit clear"); // RL11

    property p_release;
        host_wr && host_addr == SPCC_A_CMD && host_wdata[SPCC_B_REL] && s_reg.done
            |=> !s_reg.done && buf2_in_ready;
    endproperty
    a_release: assert property (p_release) else $error("buffer two not released"); // RL13

    property p_irq2;
        host_rd && host_addr == SPCC_A_IRQ && s_reg.done |=> host_rdata[SPCC_B_IRQ2];
    endproperty
    a_irq2: assert property (p_irq2) else $error("interrupt bit two missing"); // RL14
endmodule // spcc_top

// >>> test/spcc_host_model.sv
// host-side bus model for parallel and serial register access
`timescale 1ns/1ps
module spcc_host_model (
    input wire logic core_clk,
    output logic [2:0] host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic host_rvalid,
    output logic [7:0] i2c_addr,
    output logic i2c_wr,
    output logic i2c_rd,
    output logic [7:0] i2c_wdata,
    input wire logic [7:0] i2c_rdata,
    input wire logic i2c_rvalid
);
    // idle bus at time zero
    initial begin
        host_addr = 3'h0;
        host_wr = 1'h0;
        host_rd = 1'h0;
        host_wdata = 16'h0000;
        i2c_addr = 8'h00;
        i2c_wr = 1'h0;
        i2c_rd = 1'h0;
        i2c_wdata = 8'h00;
    end
    // one-cycle write strobe; released lines show the inverse, not a stale value
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'h1;
        @(posedge core_clk);
        host_wr <= 1'h0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask
    // read answer is sampled 1 ns after the edge that takes the read; missing answer gives x
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge core_clk);
        host_addr <= a;
        host_rd <= 1'h1;
        @(posedge core_clk);
        host_rd <= 1'h0;
        host_addr <= ~a;
        #1;
        d = (host_rvalid === 1'h1) ? host_rdata : 16'hxxxx;
    endtask
    // serial path write, same strobe shape
    task automatic iwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        i2c_addr <= a;
        i2c_wdata <= d;
        i2c_wr <= 1'h1;
        @(posedge core_clk);
        i2c_wr <= 1'h0;
        i2c_addr <= ~a;
        i2c_wdata <= ~d;
    endtask
    // serial path read
    task automatic ird(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        i2c_addr <= a;
        i2c_rd <= 1'h1;
        @(posedge core_clk);
        i2c_rd <= 1'h0;
        i2c_addr <= ~a;
        #1;
        d = (i2c_rvalid === 1'h1) ? i2c_rdata : 8'hxx;
    endtask
endmodule // spcc_host_model

// >>> test/tb_switch_port_control_config.sv
// self-checking bench for the port control and buffer-two block
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb_switch_port_control_config;
    import spcc_pkg::*;
    //------------------------------------------------------------------
    // signals and instances
    //------------------------------------------------------------------
    logic core_clk, rst_n, buf2_in_valid, buf2_in_last, buf2_in_ready, mii_port_up;
    logic [1:0] host_mode;
    logic [15:0] buf2_in_data, host_rdata, host_wdata, d;
    logic [2:0] host_addr;
    logic host_wr, host_rd, host_rvalid, i2c_wr, i2c_rd, i2c_rvalid;
    logic [7:0] i2c_addr, i2c_wdata, i2c_rdata, b;
    logic [9:0] fc_enable, half_duplex, speed_10, autoneg_en;
    logic [9:0] pause_tx_en, pause_rx_en, stp_forward, stp_learn;
    int n_mismatch, total_checks;
    // small buffer so a short frame fills it
    spcc_top #(.BUF2_DEPTH(4)) spcc_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .host_mode(host_mode), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .i2c_addr(i2c_addr), .i2c_wr(i2c_wr), .i2c_rd(i2c_rd), .i2c_wdata(i2c_wdata),
        .i2c_rdata(i2c_rdata), .i2c_rvalid(i2c_rvalid), .buf2_in_valid(buf2_in_valid),
        .buf2_in_data(buf2_in_data), .buf2_in_last(buf2_in_last),
        .buf2_in_ready(buf2_in_ready), .fc_enable(fc_enable), .half_duplex(half_duplex),
        .speed_10(speed_10), .autoneg_en(autoneg_en), .pause_tx_en(pause_tx_en),
        .pause_rx_en(pause_rx_en), .stp_forward(stp_forward), .stp_learn(stp_learn),
        .mii_port_up(mii_port_up));
    spcc_host_model spcc_host_model_i (.core_clk(core_clk), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .i2c_addr(i2c_addr),
        .i2c_wr(i2c_wr), .i2c_rd(i2c_rd), .i2c_wdata(i2c_wdata), .i2c_rdata(i2c_rdata),
        .i2c_rvalid(i2c_rvalid));
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // outputs land on the edge that takes the write strobe; wait two edges more
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // indirect port register access through index then data
    task automatic preg_wr(input int idx, input logic [7:0] v);
        spcc_host_model_i.wr(SPCC_A_IDX_LO, 16'(idx));
        spcc_host_model_i.wr(SPCC_A_DATA, {8'h00, v});
    endtask
    task automatic preg_rd(input int idx, output logic [15:0] v);
        spcc_host_model_i.wr(SPCC_A_IDX_LO, 16'(idx));
        spcc_host_model_i.rd(SPCC_A_DATA, v);
    endtask
    // packed view: fc, pause tx, pause rx, half, 10M, autoneg, forward, learn
    function automatic logic [7:0] outv(input int p);
        return {fc_enable[p], pause_tx_en[p], pause_rx_en[p], half_duplex[p], speed_10[p],
            autoneg_en[p], stp_forward[p], stp_learn[p]};
    endfunction
    // offer n words back to back, last on the final one; bounded wait on ready
    task automatic push(input int n);
        int w;
        logic rdy;
        @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            buf2_in_valid <= 1'h1;
            buf2_in_data <= 16'ha5c0 + 16'(i);
            buf2_in_last <= (i == n - 1);
            w = 0;
            do begin
                #1;
                rdy = buf2_in_ready;
                @(posedge core_clk);
                w++;
            end while (rdy !== 1'h1 && w < 20);
            if (rdy !== 1'h1) begin
                `CHK(rdy, 1'h1)
                close_out();
            end
        end
        buf2_in_valid <= 1'h0;
        buf2_in_data <= 16'h5a3f;
        buf2_in_last <= 1'h0;
    endtask
    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task automatic t_reset();
        for (int p = 0; p < 10; p++) begin
            preg_rd(2 * p, d);
            `CHK(d, 16'h00c0)
        end
        `CHK(outv(1), 8'he7)
        `CHK(outv(8), 8'h03)
        `CHK(mii_port_up, 1'h0)
    endtask
    // each value shows at the outputs and reads back whole
    task automatic t_mac();
        logic [7:0] wv [4] = '{8'h01, 8'ha6, 8'h48, 8'hc0};
        logic [7:0] ev [4] = '{8'h04, 8'hbd, 8'he0, 8'he7};
        for (int i = 0; i < 4; i++) begin
            preg_wr(2, wv[i]);
            settle();
            `CHK(outv(1), ev[i])
            preg_rd(2, d);
            `CHK(d, {8'h00, wv[i]})
        end
    endtask
    // the same register seen from both paths; odd index is not a port register
    task automatic t_serial();
        spcc_host_model_i.iwr(8'h09, 8'h26);
        preg_rd(18, d);
        `CHK(d, 16'h0026)
        preg_wr(0, 8'h81);
        spcc_host_model_i.ird(8'h00, b);
        `CHK(b, 8'h81)
        preg_wr(1, 8'h55);
        preg_rd(1, d);
        `CHK(d, 16'h0000)
        spcc_host_model_i.iwr(8'h01, 8'h5a);
        preg_rd(2, d);
        `CHK(d, 16'h005a)
    endtask
    // cpu port layout depends on the access mode strap
    task automatic t_cpu();
        preg_wr(16, 8'hff);
        settle();
        preg_rd(16, d);
        `CHK(d, 16'h00c0)
        `CHK(outv(8), 8'h03)
        @(posedge core_clk);
        host_mode <= SPCC_MODE_SER_MII;
        repeat (4) @(posedge core_clk);
        preg_wr(16, 8'hfc);
        settle();
        `CHK(mii_port_up, 1'h1)
        `CHK(outv(8), 8'hab)
        preg_rd(16, d);
        `CHK(d, 16'h00fc)
        preg_wr(16, 8'hf4);
        settle();
        `CHK(mii_port_up, 1'h0)
        // 8-bit mode: index from two bytes; leaving mii masks the cpu bits
        @(posedge core_clk);
        host_mode <= SPCC_MODE_PAR8;
        repeat (4) @(posedge core_clk);
        spcc_host_model_i.wr(SPCC_A_IDX_HI, 16'h0001);
        spcc_host_model_i.wr(SPCC_A_IDX_LO, 16'hff10);
        spcc_host_model_i.rd(SPCC_A_DATA, d);
        `CHK(d, 16'h0000)
        spcc_host_model_i.wr(SPCC_A_IDX_HI, 16'h0000);
        spcc_host_model_i.rd(SPCC_A_DATA, d);
        `CHK(d, 16'h00c0)
        `CHK(outv(8), 8'h03)
    endtask
    // fill a frame, see status and interrupt, drain in order, release
    task automatic t_buf2();
        spcc_host_model_i.rd(SPCC_A_BUF2, d);
        `CHK(d, 16'h0000)
        push(4);
        @(posedge core_clk);
        #1;
        `CHK(buf2_in_ready, 1'h0)
        spcc_host_model_i.rd(SPCC_A_CMD, d);
        `CHK(d[SPCC_B_REL], 1'h1)
        spcc_host_model_i.rd(SPCC_A_IRQ, d);
        `CHK(d[SPCC_B_IRQ2], 1'h1)
        for (int i = 0; i < 4; i++) begin
            spcc_host_model_i.rd(SPCC_A_BUF2, d);
            `CHK(d, 16'ha5c0 + 16'(i))
        end
        spcc_host_model_i.rd(SPCC_A_BUF2, d);
        `CHK(d, 16'h0000)
        spcc_host_model_i.wr(SPCC_A_CMD, 16'h0004);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(buf2_in_ready, 1'h1)
        spcc_host_model_i.rd(SPCC_A_IRQ, d);
        `CHK(d[SPCC_B_IRQ2], 1'h0)
    endtask
    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        core_clk = 1'h0;
        rst_n = 1'h0;
        host_mode = SPCC_MODE_PAR16;
        buf2_in_valid = 1'h0;
        buf2_in_data = 16'h0000;
        buf2_in_last = 1'h0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        // mode strap needs its synchroniser to settle
        repeat (3) @(posedge core_clk);
        t_reset();
        t_mac();
        t_serial();
        t_cpu();
        t_buf2();
        close_out();
    end
endmodule // tb_switch_port_control_config
